// *** dpc_pkg.sv ***
package dpc_pkg;

  // Width of a word address on one port.
  localparam int ADDR_W = 16;
  // Width of one data word.
  localparam int DATA_W = 8;
  // Number of words in the memory.
  localparam int DEPTH = 65536;
  // Number of address bits that pick a flag in flag space.
  localparam int FLAG_SEL_W = 3;

  // Time that the strobes are held active, in nanoseconds.
  localparam int STROBE_NS = 40;
  // Clock period in nanoseconds.
  localparam int CLK_NS = 20;
  // Cycles that an active strobe is held, rounded up, at least one.
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // Time between strobe end and the next access, in nanoseconds.
  localparam int RECOVER_NS = 20;
  // Cycles of recovery, rounded up, at least one.
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  // Width of the cycle counter.
  localparam int CNT_W = 4;

  // Values after reset of the pin drivers.
  localparam logic PIN_SEL_N_RST = 1'b1;
  localparam logic PIN_SEL_HI_RST = 1'b0;
  localparam logic PIN_WE_N_RST = 1'b1;
  localparam logic PIN_OE_N_RST = 1'b1;
  localparam logic PIN_FLAG_N_RST = 1'b1;

  // Kinds of request that the user side may make.
  typedef enum logic [1:0] {
    DPC_OP_READ = 2'b00,
    DPC_OP_WRITE = 2'b01,
    DPC_OP_FLAG_READ = 2'b10,
    DPC_OP_FLAG_WRITE = 2'b11
  } dpc_op_t;

  // States of one port sequencer.
  typedef enum logic [3:0] {
    DPC_IDLE = 4'b0001,
    DPC_SETUP = 4'b0010,
    DPC_STROBE = 4'b0100,
    DPC_RECOVER = 4'b1000
  } dpc_state_t;

endpackage

// *** dpc_sync.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser for inputs that come from the pins.
module dpc_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1;

  // The first stage is read only by the second stage.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule

// *** dpc_port_ctrl.sv ***
`timescale 1ns/1ps
// This controller drives one port of the memory; instantiate it once per port.
module dpc_port_ctrl (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic                        req_valid,
  input  wire dpc_pkg::dpc_op_t            req_op,
  input  wire logic [dpc_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [dpc_pkg::DATA_W-1:0]  req_wdata,
  input  wire logic                        bank_hit,
  output logic                             req_ready,
  output logic                             rsp_valid,
  output logic      [dpc_pkg::DATA_W-1:0]  rsp_rdata,
  output logic                             busy_seen,
  output logic                             intr_seen,
  output logic                             port_select_n,
  output logic                             port_select_hi,
  output logic                             write_n,
  output logic                             out_gate_n,
  output logic                             flag_space_select_n,
  output logic      [dpc_pkg::ADDR_W-1:0]  addr,
  output logic      [dpc_pkg::DATA_W-1:0]  data_out,
  output logic                             data_oe,
  input  wire logic [dpc_pkg::DATA_W-1:0]  data_in,
  input  wire logic                        busy_n,
  input  wire logic                        intr_n
);

  dpc_pkg::dpc_state_t             state;
  dpc_pkg::dpc_op_t                op;
  logic [dpc_pkg::CNT_W-1:0]       cnt;
  logic [dpc_pkg::DATA_W-1:0]      data_sync;
  logic                            busy_sync_n;
  logic                            intr_sync_n;
  logic                            stall;
  logic                            hit;

  // Decodes whether a kind of request goes to flag space.
  function automatic logic is_flag(input dpc_pkg::dpc_op_t o);
    is_flag = (o == dpc_pkg::DPC_OP_FLAG_READ) || (o == dpc_pkg::DPC_OP_FLAG_WRITE);
  endfunction

  // Decodes whether a kind of request writes.
  function automatic logic is_write(input dpc_pkg::dpc_op_t o);
    is_write = (o == dpc_pkg::DPC_OP_WRITE) || (o == dpc_pkg::DPC_OP_FLAG_WRITE);
  endfunction

  // Pin inputs pass two flip-flops before any logic reads them.
  dpc_sync #(
    .W(dpc_pkg::DATA_W + 2)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       ({data_in, busy_n, intr_n}),
    .q       ({data_sync, busy_sync_n, intr_sync_n})
  );

  // A slave's busy input stretches the strobe of a memory access while the arbiter holds it low; flag accesses ignore it.
  assign stall = !busy_sync_n && !is_flag(op);

  // Sequencer: setup, strobe for the set time, then recovery.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= dpc_pkg::DPC_IDLE;
      cnt   <= '0;
      op    <= dpc_pkg::DPC_OP_READ;
    end else begin
      case (state)
        dpc_pkg::DPC_IDLE: begin
          if (req_valid && req_ready) begin
            op    <= req_op;
            state <= dpc_pkg::DPC_SETUP;
          end
        end
        dpc_pkg::DPC_SETUP: begin
          cnt   <= dpc_pkg::CNT_W'(dpc_pkg::STROBE_CYC);
          state <= dpc_pkg::DPC_STROBE;
        end
        dpc_pkg::DPC_STROBE: begin
          if (!stall) begin
            if (cnt <= 1) begin
              cnt   <= dpc_pkg::CNT_W'(dpc_pkg::RECOVER_CYC);
              state <= dpc_pkg::DPC_RECOVER;
            end else begin
              cnt <= cnt - 1'b1;
            end
          end
        end
        dpc_pkg::DPC_RECOVER: begin
          if (cnt <= 1) begin
            state <= dpc_pkg::DPC_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: begin
          state <= dpc_pkg::DPC_IDLE;
        end
      endcase
    end
  end

  // Request is accepted only in idle; ready is a registered level.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state == dpc_pkg::DPC_IDLE) && !(req_valid && req_ready)
                   || (state == dpc_pkg::DPC_RECOVER && cnt <= 1);
    end
  end

  // Address, data and bank hit are latched with the request and held for the access.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addr     <= '0;
      data_out <= '0;
      hit      <= 1'b0;
    end else if (state == dpc_pkg::DPC_IDLE && req_valid && req_ready) begin
      addr     <= req_addr;
      data_out <= req_wdata;
      hit      <= bank_hit; // The bank choice may change once the request is taken.
    end
  end

  // Chip enables and flag select follow the sequencer state.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      port_select_n       <= dpc_pkg::PIN_SEL_N_RST;
      port_select_hi      <= dpc_pkg::PIN_SEL_HI_RST;
      flag_space_select_n <= dpc_pkg::PIN_FLAG_N_RST;
    end else if (state == dpc_pkg::DPC_SETUP || state == dpc_pkg::DPC_STROBE) begin
      port_select_n       <= !(hit && !is_flag(op));
      port_select_hi      <= hit && !is_flag(op);
      flag_space_select_n <= !(hit && is_flag(op));
    end else begin
      port_select_n       <= 1'b1;
      port_select_hi      <= 1'b0;
      flag_space_select_n <= 1'b1;
    end
  end

  // Write strobe, output gate and data drive during the strobe phase.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      write_n    <= dpc_pkg::PIN_WE_N_RST;
      out_gate_n <= dpc_pkg::PIN_OE_N_RST;
      data_oe    <= 1'b0;
    end else if (state == dpc_pkg::DPC_SETUP
                 || (state == dpc_pkg::DPC_STROBE && (stall || cnt > 1))) begin
      write_n    <= !is_write(op);
      out_gate_n <= is_write(op);
      data_oe    <= is_write(op) && hit; // A deselected port must not see driven data.
    end else begin
      write_n    <= 1'b1;
      out_gate_n <= 1'b1;
      data_oe    <= 1'b0;
    end
  end

  // Read data is taken in the first recovery cycle, once it has passed both sync stages.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= state == dpc_pkg::DPC_RECOVER
                   && cnt == dpc_pkg::CNT_W'(dpc_pkg::RECOVER_CYC) && !is_write(op);
      if (state == dpc_pkg::DPC_RECOVER
          && cnt == dpc_pkg::CNT_W'(dpc_pkg::RECOVER_CYC) && !is_write(op)) begin
        rsp_rdata <= data_sync;
      end
    end
  end

  // Busy and interrupt levels as seen at the pins.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy_seen <= 1'b0;
      intr_seen <= 1'b0;
    end else begin
      busy_seen <= !busy_sync_n;
      intr_seen <= !intr_sync_n;
    end
  end

  strobe_excl_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(!write_n && !out_gate_n)) else $error("write and output gate both low");

  drive_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    data_oe |-> out_gate_n) else $error("data driven while output gate low");

  flag_excl_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !flag_space_select_n |-> port_select_n && !port_select_hi)
    else $error("flag select with chip enabled");

  select_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    port_select_n == !port_select_hi) else $error("selects out of step");

  idle_desel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(state) == dpc_pkg::DPC_IDLE |-> port_select_n && flag_space_select_n)
    else $error("selected while idle");

  read_rsp_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(out_gate_n) && busy_sync_n |-> ##[1:4] rsp_valid)
    else $error("read without response");

  desel_float_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    port_select_n && flag_space_select_n |-> !data_oe) else $error("drive while deselected");

  busy_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == dpc_pkg::DPC_STROBE && stall |=> state == dpc_pkg::DPC_STROBE)
    else $error("strobe ended while busy");

endmodule

// *** dpc_dev_model.sv ***
`timescale 1ns/1ps
// Behavioural model of one port of the dual-port memory.
module dpc_dev_model (
  input  wire logic        port_select_n,
  input  wire logic        port_select_hi,
  input  wire logic        write_n,
  input  wire logic        out_gate_n,
  input  wire logic        flag_space_select_n,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  data_out,
  input  wire logic        data_oe,
  input  wire logic        busy_req,
  input  wire logic        intr_req,
  output logic      [7:0]  data_in,
  output logic             busy_n,
  output logic             intr_n,
  output logic             misuse
);
  logic [7:0] mem [0:65535];
  logic [7:0] flags = 8'h00;
  logic [7:0] last  = 8'h00;
  logic       sel;
  logic       drive;
  logic [7:0] word;
  initial misuse = 1'b0;
  assign sel = !port_select_n && port_select_hi;
  // Drive only in a read of one space.
  assign drive = write_n && !out_gate_n && (sel != !flag_space_select_n);
  assign word = sel ? mem[addr] : {8{flags[addr[2:0]]}};
  // Released lines show the inverse of the last value.
  always @* if (drive) last = word;
  assign data_in = drive ? word : ~last;
  // Writes land while the strobe is low.
  always @* begin
    if (!write_n && sel && flag_space_select_n) mem[addr] = data_out;
    if (!write_n && !sel && !flag_space_select_n) flags[addr[2:0]] = data_out[0];
  end
  assign busy_n = !busy_req;
  assign intr_n = !intr_req;
  // Host misuse: both selects, or driving into a read.
  always @* if ((sel && !flag_space_select_n) || (data_oe && drive)) misuse = 1'b1;
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
// Self-checking bench for one port controller and its memory model.
module tb_top;
  logic             sys_clk   = 1'b0;
  logic             rst_n     = 1'b0;
  logic             req_valid = 1'b0;
  dpc_pkg::dpc_op_t req_op    = dpc_pkg::DPC_OP_READ;
  logic [15:0]      req_addr  = 16'h0000;
  logic [7:0]       req_wdata = 8'h00;
  logic             bank_hit  = 1'b1;
  logic             busy_req  = 1'b0;
  logic             intr_req  = 1'b0;
  logic             req_ready, rsp_valid, busy_seen, intr_seen, misuse;
  logic             sel_n, sel_hi, write_n, gate_n, flag_n, data_oe, busy_n, intr_n;
  logic [7:0]       rsp_rdata, data_out, data_in, rd;
  logic [15:0]      addr;
  int               bad_count = 0;
  int               tests_run = 0;
  int               lowcnt = 0;
  dpc_port_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .bank_hit(bank_hit),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .busy_seen(busy_seen), .intr_seen(intr_seen), .port_select_n(sel_n),
    .port_select_hi(sel_hi), .write_n(write_n), .out_gate_n(gate_n),
    .flag_space_select_n(flag_n), .addr(addr), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .busy_n(busy_n), .intr_n(intr_n));
  dpc_dev_model dev_u (.port_select_n(sel_n), .port_select_hi(sel_hi), .write_n(write_n),
    .out_gate_n(gate_n), .flag_space_select_n(flag_n), .addr(addr), .data_out(data_out),
    .data_oe(data_oe), .busy_req(busy_req), .intr_req(intr_req), .data_in(data_in),
    .busy_n(busy_n), .intr_n(intr_n), .misuse(misuse));
  // Clock of 20 ns period.
  always #10 sys_clk = ~sys_clk;
  // Counts the edges that see the write strobe low.
  always @(posedge sys_clk) if (write_n === 1'b0) lowcnt++;
  // Compares one value and counts the outcome.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic finish_test();
    $display("Mismatches %0d, comparisons %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One access: hold the request until taken, wait for read data.
  task automatic op(input dpc_pkg::dpc_op_t k, input logic [15:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    @(negedge sys_clk);
    req_valid = 1'b1;
    req_op = k;
    req_addr = a;
    req_wdata = wd;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    req_valid = 1'b0;
    check(16'(n == 50), 16'h0000);
    n = 0;
    if (k == dpc_pkg::DPC_OP_READ || k == dpc_pkg::DPC_OP_FLAG_READ) begin
      while (rsp_valid !== 1'b1 && n < 50) begin
        @(negedge sys_clk);
        n++;
      end
      rd = rsp_rdata;
      check(16'(n == 50), 16'h0000);
    end
  endtask
  // Pin levels held in reset.
  task automatic t_reset();
    check({10'h000, sel_n, sel_hi, write_n, gate_n, flag_n, data_oe}, {10'h000,
      dpc_pkg::PIN_SEL_N_RST, dpc_pkg::PIN_SEL_HI_RST, dpc_pkg::PIN_WE_N_RST,
      dpc_pkg::PIN_OE_N_RST, dpc_pkg::PIN_FLAG_N_RST, 1'b0});
  endtask
  // Writes at both end addresses and one address inside, then reads them back to back.
  task automatic t_mem();
    logic [15:0] a [3] = '{16'h0000, 16'hFFFF, 16'h1234};
    lowcnt = 0;
    op(dpc_pkg::DPC_OP_WRITE, a[0], 8'h5A);
    op(dpc_pkg::DPC_OP_READ, a[0], 8'h00);
    check(16'(lowcnt), 16'(dpc_pkg::STROBE_CYC));
    for (int i = 1; i < 3; i++) op(dpc_pkg::DPC_OP_WRITE, a[i], 8'(i * 8'h33));
    for (int i = 0; i < 3; i++) begin
      op(dpc_pkg::DPC_OP_READ, a[i], 8'h00);
      check({8'h00, rd}, {8'h00, (i == 0) ? 8'h5A : 8'(i * 8'h33)});
      check({8'h00, dev_u.mem[a[i]]}, {8'h00, rd});
    end
  endtask
  // Flag space: set one flag, clear another, read both.
  task automatic t_flag();
    op(dpc_pkg::DPC_OP_FLAG_WRITE, 16'h0003, 8'h01);
    op(dpc_pkg::DPC_OP_FLAG_WRITE, 16'h0005, 8'h00);
    op(dpc_pkg::DPC_OP_FLAG_READ, 16'h0003, 8'h00);
    check({8'h00, rd}, 16'h00FF);
    op(dpc_pkg::DPC_OP_FLAG_READ, 16'h0005, 8'h00);
    check({8'h00, rd}, 16'h0000);
  endtask
  // A write to another bank must leave this device untouched.
  task automatic t_bank();
    op(dpc_pkg::DPC_OP_WRITE, 16'h0010, 8'hC3);
    bank_hit = 1'b0;
    op(dpc_pkg::DPC_OP_WRITE, 16'h0010, 8'h3C);
    bank_hit = 1'b1;
    op(dpc_pkg::DPC_OP_READ, 16'h0010, 8'h00);
    check({8'h00, rd}, 16'h00C3);
  endtask
  // Busy stretches the write strobe; flags reach the user side.
  task automatic t_busy();
    busy_req = 1'b1;
    intr_req = 1'b1;
    repeat (4) @(negedge sys_clk);
    check({14'h0000, busy_seen, intr_seen}, 16'h0003);
    lowcnt = 0;
    fork
      op(dpc_pkg::DPC_OP_WRITE, 16'h0020, 8'h96);
      begin
        repeat (12) @(negedge sys_clk);
        busy_req = 1'b0;
        intr_req = 1'b0;
      end
    join
    op(dpc_pkg::DPC_OP_READ, 16'h0020, 8'h00);
    check(16'(lowcnt > dpc_pkg::STROBE_CYC + 4), 16'h0001);
    check({7'h00, busy_seen, rd}, 16'h0096);
    check({15'h0000, misuse}, 16'h0000);
  endtask
  // Main sequence.
  initial begin
    repeat (10) @(negedge sys_clk);
    t_reset();
    rst_n = 1'b1;
    t_mem();
    t_flag();
    t_bank();
    t_busy();
    finish_test();
  end
  // Watchdog for a hung handshake.
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
endmodule
